// >>> verilog/cesf_pkg.sv
package cesf_pkg;

    // Register offsets, byte addresses on the plain register port.
    localparam logic [7:0]  CESF_ES_OFS    = 8'h00;
    localparam logic [7:0]  CESF_MC_OFS    = 8'h04;
    localparam logic [7:0]  CESF_EC_OFS    = 8'h08;
    localparam logic [7:0]  CESF_IS_OFS    = 8'h0c;
    localparam logic [7:0]  CESF_IM_OFS    = 8'h10;

    // Field positions in error_status_reg.
    localparam int          CESF_FE_BIT    = 24;
    localparam int          CESF_BE_BIT    = 23;
    localparam int          CESF_SA_BIT    = 22;
    localparam int          CESF_CRC_BIT   = 21;
    localparam int          CESF_SE_BIT    = 20;
    localparam int          CESF_ACK_BIT   = 19;
    localparam int          CESF_BO_BIT    = 18;
    localparam int          CESF_EP_BIT    = 17;
    localparam int          CESF_EW_BIT    = 16;

    // Field positions in master_control_reg and the counter register.
    localparam int          CESF_CCR_BIT   = 12;
    localparam int          CESF_ABO_BIT   = 7;
    localparam int          CESF_SRST_BIT  = 5;
    localparam int          CESF_TEC_LSB   = 0;
    localparam int          CESF_REC_LSB   = 16;

    // Interrupt status and mask layout.
    localparam int          CESF_IRQ_ERR   = 0;
    localparam int          CESF_IRQ_BOFF  = 1;
    localparam int          CESF_IRQ_BON   = 2;

    // Values after reset.
    localparam logic        CESF_CCR_RST   = 1'b1;
    localparam logic        CESF_ABO_RST   = 1'b0;
    localparam logic [2:0]  CESF_IM_RST    = 3'h0;

    // Counter thresholds and the auto bus-on bit count.
    localparam logic [8:0]  CESF_TEC_LIMIT = 9'h100;
    localparam logic [8:0]  CESF_EP_LEVEL  = 9'h080;
    localparam logic [8:0]  CESF_EW_LEVEL  = 9'h060;
    localparam int          CESF_BON_BITS  = 128 * 11;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } cesf_bus_req_t;

    // One-cycle error pulses from the protocol engine.
    typedef struct packed {
        logic form;
        logic bit_mis;
        logic crc;
        logic stuff;
        logic ack;
    } cesf_err_evt_t;

    // Error counter update requests from the protocol engine.
    typedef struct packed {
        logic tec_up8;
        logic tec_dn1;
        logic rec_up1;
        logic rec_up8;
        logic rec_dn1;
    } cesf_cnt_cmd_t;

    // One sampled bus bit: tick marks the sample, recessive is its level.
    typedef struct packed {
        logic tick;
        logic recessive;
    } cesf_bit_t;

    typedef enum logic [1:0] {
        CESF_ACTIVE = 2'b01,
        CESF_BUSOFF = 2'b10
    } cesf_state_t;

endpackage : cesf_pkg

// >>> verilog/cesf_top.sv
module cesf_top
    import cesf_pkg::*;
#(
    parameter int BON_BITS = CESF_BON_BITS
) (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire cesf_bus_req_t bus_req,
    output logic [31:0]        rd_data_r,
    input  wire cesf_bit_t     rx_bit,
    input  wire cesf_err_evt_t err_evt,
    input  wire cesf_cnt_cmd_t cnt_cmd,
    output logic               bus_off_r,
    output logic               irq_r
);

    initial begin
        if (BON_BITS < 2 || BON_BITS > 4095) begin
            $error("BON_BITS must lie in 2..4095");
        end
    end

    localparam logic [11:0] BON_LAST = 12'(BON_BITS - 1);

    cesf_state_t  state_r;
    cesf_state_t  state_nxt;
    logic [4:0]   errf_r;
    logic [4:0]   errf_nxt;
    logic [4:0]   errf_evt;
    logic [4:0]   errf_clr;
    logic [4:0]   errf_kept;
    logic         sa1_r;
    logic [8:0]   tec_r;
    logic [8:0]   tec_nxt;
    logic [7:0]   rec_r;
    logic [7:0]   rec_nxt;
    logic         ccr_r;
    logic         abo_r;
    logic [11:0]  bon_cnt_r;
    logic [2:0]   int_sts_r;
    logic [2:0]   int_sts_nxt;
    logic [2:0]   int_evt;
    logic [2:0]   int_mask_r;
    logic [31:0]  es_val;
    logic [31:0]  rd_val;
    logic         wr_es;
    logic         wr_mc;
    logic         wr_is;
    logic         wr_im;
    logic         soft_rst;
    logic         ccr_clr;
    logic         auto_on;
    logic         enter_boff;
    logic         leave_boff;
    logic         err_passive;
    logic         err_warning;

    // Address decode for writes.
    always_comb begin
        wr_es = 1'b0;
        wr_mc = 1'b0;
        wr_is = 1'b0;
        wr_im = 1'b0;
        if (!bus_req.wr) begin
            wr_es = 1'b0;
        end else if (bus_req.addr == CESF_ES_OFS) begin
            wr_es = 1'b1;
        end else if (bus_req.addr == CESF_MC_OFS) begin
            wr_mc = 1'b1;
        end else if (bus_req.addr == CESF_IS_OFS) begin
            wr_is = 1'b1;
        end else if (bus_req.addr == CESF_IM_OFS) begin
            wr_im = 1'b1;
        end
    end

    // The software reset bit is a self-clearing strobe, so it never reads back as one.
    assign soft_rst = wr_mc && bus_req.wdata[CESF_SRST_BIT];
    assign ccr_clr  = wr_mc && !bus_req.wdata[CESF_CCR_BIT] && ccr_r;
    assign auto_on  = abo_r && rx_bit.tick && (bon_cnt_r == BON_LAST);

    // Error counters, saturating so that no increment wraps past the bus-off limit.
    always_comb begin
        tec_nxt = tec_r;
        rec_nxt = rec_r;
        if (cnt_cmd.tec_up8) begin
            tec_nxt = (tec_r >= CESF_TEC_LIMIT - 9'h008) ? CESF_TEC_LIMIT : tec_r + 9'h008;
        end else if (cnt_cmd.tec_dn1 && tec_r != 9'h000) begin
            tec_nxt = tec_r - 9'h001;
        end
        if (cnt_cmd.rec_up8) begin
            rec_nxt = (rec_r >= 8'hf7) ? 8'hff : rec_r + 8'h08;
        end else if (cnt_cmd.rec_up1) begin
            rec_nxt = (rec_r == 8'hff) ? 8'hff : rec_r + 8'h01;
        end else if (cnt_cmd.rec_dn1 && rec_r != 8'h00) begin
            rec_nxt = rec_r - 8'h01;
        end
    end

    // Bus-off state machine.
    always_comb begin
        state_nxt  = state_r;
        enter_boff = 1'b0;
        leave_boff = 1'b0;
        case (state_r)
            CESF_ACTIVE: begin
                if (tec_nxt == CESF_TEC_LIMIT) begin
                    state_nxt  = CESF_BUSOFF;
                    enter_boff = 1'b1;
                end
            end
            CESF_BUSOFF: begin
                if (ccr_clr || auto_on) begin
                    state_nxt  = CESF_ACTIVE;
                    leave_boff = 1'b1;
                end
            end
            default: begin
                state_nxt = CESF_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst || soft_rst) begin
            state_r <= CESF_ACTIVE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // The protocol engine must stay off the bus while this flag is high.
    always_ff @(posedge clk) begin
        if (sys_rst || soft_rst) begin
            bus_off_r <= 1'b0;
        end else begin
            bus_off_r <= (state_nxt == CESF_BUSOFF);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || soft_rst || leave_boff) begin
            tec_r <= 9'h000;
            rec_r <= 8'h00;
        end else if (state_r == CESF_ACTIVE) begin
            tec_r <= tec_nxt;
            rec_r <= rec_nxt;
        end
    end

    // Received bits are counted only in bus-off; the count restarts on each entry.
    always_ff @(posedge clk) begin
        if (sys_rst || soft_rst || enter_boff) begin
            bon_cnt_r <= 12'h000;
        end else if (state_r == CESF_BUSOFF && rx_bit.tick && bon_cnt_r != BON_LAST) begin
            bon_cnt_r <= bon_cnt_r + 12'h001;
        end
    end

    // Bus error flags, ordered form, bit, crc, stuff, ack.
    assign errf_clr  = wr_es ? {bus_req.wdata[CESF_FE_BIT], bus_req.wdata[CESF_BE_BIT],
                                bus_req.wdata[CESF_CRC_BIT], bus_req.wdata[CESF_SE_BIT],
                                bus_req.wdata[CESF_ACK_BIT]} : 5'h00;
    assign errf_kept = errf_r & ~errf_clr;

    // Gating on the flags that survive this cycle's acknowledge means an event
    // arriving in a cycle whose acknowledge clears every set flag is recorded instead of lost.
    always_comb begin
        errf_evt = {err_evt.form, err_evt.bit_mis, err_evt.crc, err_evt.stuff, err_evt.ack};
        if (errf_kept != 5'h00) begin
            errf_evt = 5'h00;
        end
        errf_nxt = errf_kept | errf_evt;
    end

    always_ff @(posedge clk) begin
        if (sys_rst || soft_rst) begin
            errf_r <= 5'h00;
        end else begin
            errf_r <= errf_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || soft_rst || enter_boff) begin
            sa1_r <= 1'b1;
        end else if (rx_bit.tick && rx_bit.recessive) begin
            sa1_r <= 1'b0;
        end
    end

    // Hardware raises the change request on bus-off entry so software can end it.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ccr_r <= CESF_CCR_RST;
            abo_r <= CESF_ABO_RST;
        end else begin
            if (enter_boff) begin
                ccr_r <= 1'b1;
            end else if (auto_on && state_r == CESF_BUSOFF) begin
                ccr_r <= 1'b0;
            end else if (wr_mc) begin
                ccr_r <= bus_req.wdata[CESF_CCR_BIT];
            end
            if (wr_mc) begin
                abo_r <= bus_req.wdata[CESF_ABO_BIT];
            end
        end
    end

    assign err_passive = (tec_r >= CESF_EP_LEVEL);
    assign err_warning = (tec_r >= CESF_EW_LEVEL) || ({1'b0, rec_r} >= CESF_EW_LEVEL);

    // Interrupt status: set wins over a write-one clear in the same cycle.
    always_comb begin
        int_evt                = 3'h0;
        int_evt[CESF_IRQ_ERR]  = (errf_evt != 5'h00);
        int_evt[CESF_IRQ_BOFF] = enter_boff;
        int_evt[CESF_IRQ_BON]  = leave_boff;
        int_sts_nxt            = int_sts_r;
        if (wr_is) begin
            int_sts_nxt = int_sts_r & ~bus_req.wdata[2:0];
        end
        int_sts_nxt = int_sts_nxt | int_evt;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_sts_r <= 3'h0;
        end else begin
            int_sts_r <= int_sts_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_mask_r <= CESF_IM_RST;
        end else if (wr_im) begin
            int_mask_r <= bus_req.wdata[2:0];
        end
    end

    // Using the next values keeps the line in step with the status register.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(int_sts_nxt & int_mask_r);
        end
    end

    // Status image; reserved bits stay zero.
    always_comb begin
        es_val               = 32'h0000_0000;
        es_val[CESF_FE_BIT]  = errf_r[4];
        es_val[CESF_BE_BIT]  = errf_r[3];
        es_val[CESF_SA_BIT]  = sa1_r;
        es_val[CESF_CRC_BIT] = errf_r[2];
        es_val[CESF_SE_BIT]  = errf_r[1];
        es_val[CESF_ACK_BIT] = errf_r[0];
        es_val[CESF_BO_BIT]  = (state_r == CESF_BUSOFF);
        es_val[CESF_EP_BIT]  = err_passive;
        es_val[CESF_EW_BIT]  = err_warning;
    end

    // Read decode; unmapped addresses read zero.
    always_comb begin
        rd_val = 32'h0000_0000;
        if (bus_req.addr == CESF_ES_OFS) begin
            rd_val = es_val;
        end else if (bus_req.addr == CESF_MC_OFS) begin
            rd_val[CESF_CCR_BIT] = ccr_r;
            rd_val[CESF_ABO_BIT] = abo_r;
        end else if (bus_req.addr == CESF_EC_OFS) begin
            rd_val[CESF_TEC_LSB +: 9] = tec_r;
            rd_val[CESF_REC_LSB +: 8] = rec_r;
        end else if (bus_req.addr == CESF_IS_OFS) begin
            rd_val[2:0] = int_sts_r;
        end else if (bus_req.addr == CESF_IM_OFS) begin
            rd_val[2:0] = int_mask_r;
        end
    end

    // Reads have no side effect; data stand only in the cycle after the strobe.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_r <= 32'h0000_0000;
        end else if (bus_req.rd) begin
            rd_data_r <= rd_val;
        end else begin
            rd_data_r <= 32'h0000_0000;
        end
    end

endmodule : cesf_top

// >>> verification/cesf_assertions.sv
module cesf_assertions
    import cesf_pkg::*;
#(
    parameter int BON_BITS = CESF_BON_BITS
) (
    input wire logic          clk,
    input wire logic          sys_rst,
    input wire cesf_bus_req_t bus_req,
    input wire logic [31:0]   rd_data_r,
    input wire cesf_bit_t     rx_bit,
    input wire cesf_err_evt_t err_evt,
    input wire cesf_cnt_cmd_t cnt_cmd,
    input wire logic          bus_off_r,
    input wire logic          irq_r
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        mc_wr;
    logic        es_rd;
    logic        bon_last;
    logic        abo_r;
    logic [2:0]  mask_r;
    logic [15:0] ticks_r;

    assign mc_wr    = bus_req.wr && bus_req.addr == CESF_MC_OFS;
    assign es_rd    = bus_req.rd && bus_req.addr == CESF_ES_OFS;
    assign bon_last = abo_r && rx_bit.tick && ticks_r == 16'(BON_BITS - 1);

    // Shadow copies of the control bits, since the checker cannot see inside.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            abo_r <= CESF_ABO_RST;
        end else if (mc_wr) begin
            abo_r <= bus_req.wdata[CESF_ABO_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mask_r <= CESF_IM_RST;
        end else if (bus_req.wr && bus_req.addr == CESF_IM_OFS) begin
            mask_r <= bus_req.wdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !bus_off_r) begin
            ticks_r <= 16'h0000;
        end else if (rx_bit.tick) begin
            ticks_r <= ticks_r + 16'h0001;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_rd_idle;
        !bus_req.rd |=> rd_data_r == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

    property p_rsvd;
        es_rd |=> rd_data_r[31:25] == 7'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");

    property p_bo_stat;
        es_rd |=> rd_data_r[CESF_BO_BIT] == $past(bus_off_r);
    endproperty
    a_bo_stat: assert property (p_bo_stat) else $error("bus-off bit wrong");

    property p_bo_hold;
        bus_off_r && !mc_wr && !bon_last |=> bus_off_r;
    endproperty
    a_bo_hold: assert property (p_bo_hold) else $error("bus-off left early");

    property p_bo_ccr;
        bus_off_r && mc_wr && !bus_req.wdata[CESF_CCR_BIT] |=> !bus_off_r;
    endproperty
    a_bo_ccr: assert property (p_bo_ccr) else $error("bus-off not left");

    property p_sa_entry;
        $rose(bus_off_r) && !(rx_bit.tick && rx_bit.recessive) ##1 es_rd
            |=> rd_data_r[CESF_SA_BIT];
    endproperty
    a_sa_entry: assert property (p_sa_entry) else $error("stuck flag not set");

    property p_sa_clear;
        es_rd && !bus_off_r && !$past(sys_rst) && !$past(mc_wr)
            && $past(rx_bit.tick && rx_bit.recessive) |=> !rd_data_r[CESF_SA_BIT];
    endproperty
    a_sa_clear: assert property (p_sa_clear) else $error("stuck flag not cleared");

    property p_irq_mask;
        mask_r == 3'h0 && $past(mask_r) == 3'h0 |-> !irq_r;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt seen");

    c_ccr_exit: cover property (bus_off_r && mc_wr && !bus_req.wdata[CESF_CCR_BIT]);
    c_auto_exit: cover property (bus_off_r && bon_last);
    c_irq: cover property (irq_r);
endmodule : cesf_assertions

bind cesf_top cesf_assertions #(.BON_BITS(BON_BITS)) cesf_assertions_i (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .bus_req   (bus_req),
    .rd_data_r (rd_data_r),
    .rx_bit    (rx_bit),
    .err_evt   (err_evt),
    .cnt_cmd   (cnt_cmd),
    .bus_off_r (bus_off_r),
    .irq_r     (irq_r)
);

// >>> verification/cesf_bus_node.sv
module cesf_bus_node
    import cesf_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        start,
    input wire logic [11:0] nbits,
    input wire logic        level,
    output cesf_bit_t       rx_bit,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] left_r;
    logic [1:0]  ph_r;
    logic        lvl_r;

    assign busy = left_r != 12'h000;

    // Between bits the level toggles, so a stale level is never mistaken for a bit.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            left_r <= 12'h000;
            ph_r   <= 2'h0;
            lvl_r  <= 1'b1;
            rx_bit <= '0;
        end else if (start) begin
            left_r <= nbits;
            ph_r   <= 2'h0;
            lvl_r  <= level;
        end else begin
            rx_bit.tick      <= 1'b0;
            rx_bit.recessive <= ~rx_bit.recessive;
            if (busy) begin
                ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
                if (ph_r == 2'h2) begin
                    rx_bit.tick      <= 1'b1;
                    rx_bit.recessive <= lvl_r;
                    left_r           <= left_r - 12'h001;
                end
            end
        end
    end
endmodule : cesf_bus_node

// >>> verification/testbench.sv
module testbench;
    import cesf_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic          clk = 1'b0;
    logic          sys_rst = 1'b1;
    cesf_bus_req_t bus_req = '0;
    cesf_err_evt_t err_evt = '0;
    cesf_cnt_cmd_t cnt_cmd = '0;
    cesf_bit_t     rx_bit;
    logic [31:0]   rd_data_r;
    logic          bus_off_r;
    logic          irq_r;
    logic          start = 1'b0;
    logic          level = 1'b0;
    logic          busy;
    logic [11:0]   nbits = 12'h000;
    int            failures = 0;
    int            compares = 0;
    int            k;
    int            n;
    logic [31:0]   fl [5] = '{32'h0100_0000, 32'h0080_0000, 32'h0020_0000,
                              32'h0010_0000, 32'h0008_0000};

    always #25 clk = ~clk;

    cesf_top #(.BON_BITS(4)) cesf_top_i (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
        .rd_data_r(rd_data_r), .rx_bit(rx_bit), .err_evt(err_evt), .cnt_cmd(cnt_cmd),
        .bus_off_r(bus_off_r), .irq_r(irq_r));
    cesf_bus_node cesf_bus_node_i (.clk(clk), .sys_rst(sys_rst), .start(start),
        .nbits(nbits), .level(level), .rx_bit(rx_bit), .busy(busy));

    task tally_and_finish;
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus_req <= '0;
        @(negedge clk);
        check($sformatf("register %h", a), rd_data_r, e);
    endtask : rd

    task evt(input logic [4:0] e);
        @(posedge clk);
        err_evt <= e;
        @(posedge clk);
        err_evt <= '0;
    endtask : evt

    task cnt(input logic [4:0] c, input int m);
        repeat (m) begin
            @(posedge clk);
            cnt_cmd <= c;
            @(posedge clk);
            cnt_cmd <= '0;
        end
    endtask : cnt

    task send(input logic [11:0] m, input logic l);
        @(posedge clk);
        start <= 1'b1;
        nbits <= m;
        level <= l;
        @(posedge clk);
        start <= 1'b0;
    endtask : send

    // Waits for the partner to go idle (0), for bus-off to end (1), or for the first bit (2).
    task wait_on(input int sel);
        n = 0;
        @(negedge clk);
        while ((sel == 0 ? busy : sel == 1 ? bus_off_r : !rx_bit.tick) === 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n == 200) begin
            failures++;
            tally_and_finish();
        end
    endtask : wait_on

    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rd(CESF_ES_OFS, 32'h0040_0000);
        rd(CESF_MC_OFS, 32'h0000_1000);
        rd(CESF_EC_OFS, 32'h0);
        rd(CESF_IS_OFS, 32'h0);
        rd(CESF_IM_OFS, 32'h0);
        rd(8'h14, 32'h0);
        wr(CESF_ES_OFS, 32'hfe00_0000);
        rd(CESF_ES_OFS, 32'h0040_0000);
        send(12'h002, 1'b0);
        wait_on(0);
        rd(CESF_ES_OFS, 32'h0040_0000);
        send(12'h00c, 1'b1);
        wait_on(2);
        repeat (4) rd(CESF_ES_OFS, 32'h0);
        wr(CESF_IM_OFS, 32'h1);
        for (k = 0; k < 5; k++) begin
            evt(5'h10 >> k);
            rd(CESF_ES_OFS, fl[k]);
            check("irq_r", {31'h0, irq_r}, 32'h1);
            evt(k == 0 ? 5'h01 : 5'h10);
            rd(CESF_ES_OFS, fl[k]);
            wr(CESF_ES_OFS, fl[k]);
            rd(CESF_ES_OFS, 32'h0);
            wr(CESF_IS_OFS, 32'h1);
            rd(CESF_IS_OFS, 32'h0);
            check("irq_r", {31'h0, irq_r}, 32'h0);
        end
        wr(CESF_IM_OFS, 32'h0);
        cnt(5'h02, 12);
        rd(CESF_EC_OFS, 32'h0060_0000);
        rd(CESF_ES_OFS, 32'h0001_0000);
        cnt(5'h10, 16);
        rd(CESF_ES_OFS, 32'h0003_0000);
        cnt(5'h10, 16);
        rd(CESF_ES_OFS, 32'h0047_0000);
        check("bus_off_r", {31'h0, bus_off_r}, 32'h1);
        cnt(5'h08, 1);
        cnt(5'h02, 1);
        rd(CESF_EC_OFS, 32'h0060_0100);
        check("irq_r", {31'h0, irq_r}, 32'h0);
        wr(CESF_IM_OFS, 32'h2);
        rd(CESF_IS_OFS, 32'h2);
        check("irq_r", {31'h0, irq_r}, 32'h1);
        wr(CESF_IM_OFS, 32'h0);
        wr(CESF_MC_OFS, 32'h0);
        rd(CESF_EC_OFS, 32'h0);
        check("bus_off_r", {31'h0, bus_off_r}, 32'h0);
        rd(CESF_IS_OFS, 32'h6);
        wr(CESF_IS_OFS, 32'h6);
        wr(CESF_MC_OFS, 32'h1080);
        cnt(5'h10, 32);
        send(12'h003, 1'b1);
        wait_on(0);
        check("bus_off_r", {31'h0, bus_off_r}, 32'h1);
        send(12'h001, 1'b1);
        wait_on(1);
        rd(CESF_EC_OFS, 32'h0);
        wr(CESF_MC_OFS, 32'h20);
        rd(CESF_ES_OFS, 32'h0040_0000);
        rd(CESF_MC_OFS, 32'h0);
        tally_and_finish();
    end
endmodule : testbench
